// *** icm_pkg.sv ***
`default_nettype none
package icm_pkg;
	// ----------------------------------------
	// serial side constants
	// ----------------------------------------
	localparam logic [3:0] CODE_DEFAULT = 4'h1; // control code after reset
	localparam logic [1:0] BLK_RAM_TOP = 2'h0; // upper block bits of the ram space
	localparam logic [2:0] BLK_NVM = 3'h2; // block code of the nvm space
	localparam logic [3:0] BIT_LAST = 4'h8; // bits in one byte
	localparam logic [7:0] RD_BLOCKED = 8'hff; // read answer for blocked or unused space
	localparam logic [7:0] MACRO_BASE = 8'hf0; // four bytes of macrocell outputs
	localparam logic [7:0] SCRATCH_WORD = 8'hf8; // byte with no nvm backing
	localparam logic [7:0] BOOT_LAST = 8'hff; // last word copied at startup
	localparam logic [7:0] PROT_RESET = 8'h00; // protection bytes open after reset
	localparam int PROT_RD_INH = 0; // protection byte: read inhibit
	localparam int PROT_WR_INH = 1; // protection byte: write inhibit
	localparam int PROT_UPPER = 2; // protection byte: upper half only
	// ----------------------------------------
	// register bus map
	// ----------------------------------------
	localparam logic [7:0] REG_CODE = 8'h00; // control code value and pin selects
	localparam logic [7:0] REG_PROT = 8'h04; // protection bytes and lock
	localparam logic [7:0] REG_STATUS = 8'h08; // pointer and startup flag
	localparam logic [7:0] REG_MACRO = 8'h0c; // macrocell outputs
	localparam int PIN_SEL_LSB = 4; // pin select field in REG_CODE
	localparam int NVM_PROT_LSB = 8; // nvm protection byte in REG_PROT
	localparam int LOCK_BIT = 16; // lock bit in REG_PROT
	localparam int STAT_BOOT_BIT = 11; // startup copy running
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// serial slave states
	typedef enum logic [2:0] {
		ST_IDLE, ST_CTRL, ST_WADDR, ST_WDATA, ST_ACK, ST_READ, ST_MACK
	} icm_state_t;

	// true when the protection byte blocks this access
	function automatic logic prot_blocks(input logic [7:0] prot, input logic [7:0] word,
			input logic wr);
		logic hit;
		hit = prot[PROT_UPPER] ? word[7] : 1'b1;
		return hit && (wr ? prot[PROT_WR_INH] : prot[PROT_RD_INH]);
	endfunction
endpackage
`default_nettype wire

// *** icm_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// byte array, one write port, one direct and one registered read port
module icm_mem import icm_pkg::*; #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr_a,
	output logic [7:0] rdata_a,
	input wire logic [AW-1:0] raddr_b,
	output logic [7:0] rdata_b
);
	logic [7:0] mem [DEPTH]; // storage

	// write port
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// direct read for the serial side
	assign rdata_a = mem[raddr_a];

	// registered read for the macrocell side
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_b <= 8'h00;
		end else begin
			rdata_b <= mem[raddr_b];
		end
	end
endmodule // icm_mem
`default_nettype wire

// *** icm_axil.sv ***
`timescale 1ns/1ps
`default_nettype none
// axi4-lite register slave
module icm_axil import icm_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic [3:0] code_val,
	output logic [3:0] pin_sel,
	output logic [7:0] ram_protect_byte,
	output logic [7:0] nvm_protect_byte,
	output logic protect_lock_bit,
	input wire logic [10:0] ptr_now,
	input wire logic booting,
	input wire logic [31:0] macro_out
);
	logic aw_got, w_got; // halves of a write held
	logic [7:0] aw_addr; // held write address
	logic [31:0] w_data; // held write data
	logic [3:0] w_strb; // held byte enables

	assign awready = !aw_got && !bvalid;
	assign wready = !w_got && !bvalid;
	assign arready = !rvalid;

	// write channel: collect address and data in any order, then apply
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			code_val <= CODE_DEFAULT;
			pin_sel <= 4'h0;
			ram_protect_byte <= PROT_RESET;
			nvm_protect_byte <= PROT_RESET;
			protect_lock_bit <= 1'b0;
		end else begin
			if (awvalid && awready) begin
				aw_got <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_got <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (aw_got && w_got) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				bvalid <= 1'b1;
				bresp <= RESP_OKAY;
				if (aw_addr == REG_CODE) begin
					if (w_strb[0]) begin
						code_val <= w_data[3:0];
						pin_sel <= w_data[PIN_SEL_LSB +: 4];
					end
				end else if (aw_addr == REG_PROT) begin
					// locked protection is frozen
					if (!protect_lock_bit) begin
						if (w_strb[0]) begin
							ram_protect_byte <= w_data[7:0];
						end
						if (w_strb[1]) begin
							nvm_protect_byte <= w_data[NVM_PROT_LSB +: 8];
						end
						if (w_strb[2]) begin
							protect_lock_bit <= w_data[LOCK_BIT];
						end
					end
				end else if (aw_addr != REG_STATUS && aw_addr != REG_MACRO) begin
					bresp <= RESP_SLVERR; // unmapped
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			unique case (araddr)
				REG_CODE: rdata <= {24'h0, pin_sel, code_val};
				REG_PROT: rdata <= {15'h0, protect_lock_bit, nvm_protect_byte, ram_protect_byte};
				REG_STATUS: rdata <= {20'h0, booting, ptr_now};
				REG_MACRO: rdata <= macro_out;
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	a_lock_freezes: assert property (@(posedge clock) disable iff (!rstn)
		protect_lock_bit |=> $stable(ram_protect_byte) && $stable(nvm_protect_byte)
			&& protect_lock_bit)
		else $error("protection changed while locked");
endmodule // icm_axil
`default_nettype wire

// *** icm_i2c_slave.sv ***
//
// Function
// - hold 2048 nvm and 2048 ram bits
// - copy nvm into ram at startup
// - protection bytes inhibit ram and nvm access
// - lock bit freezes both protection bytes
// - control byte starts with four-bit code
// - each code bit from register or pin
// - default control code is 0001
// - next three bits are block address
// - last bit: one reads, zero writes
// - acknowledge a matching control byte
// - decode block bits to ram or nvm
// - pointer is block bits over word address
// - ack each data byte, master may send more or stop
// - commit data at its acknowledge
// - macrocell outputs readable as registers
// - extra register bits without nvm backing
// - further bytes go to next address
// - repeated start keeps the loaded address
//
`timescale 1ns/1ps
`default_nettype none
module icm_i2c_slave import icm_pkg::*; #(
	parameter int DEPTH = 256
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl_line,
	input wire logic sda_line,
	output logic sda_drive,
	output logic sda_oe,
	input wire logic code_pin_lsb,
	input wire logic code_pin_b1,
	input wire logic code_pin_b2,
	input wire logic code_pin_msb,
	input wire logic [31:0] macro_out,
	input wire logic [7:0] cfg_raddr,
	output logic [7:0] cfg_rdata,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	icm_state_t state; // serial state
	icm_state_t after_ack; // state entered after an ack slot
	logic scl_q, sda_q; // line values one cycle back
	logic start_seen, stop_seen; // bus conditions
	logic scl_rise, scl_fall; // clock edges
	logic [3:0] cnt; // bits moved in this byte
	logic [7:0] shreg; // received byte
	logic [7:0] tx; // byte being sent
	logic [10:0] ptr; // block bits over word address
	logic [7:0] boot_cnt; // startup copy address
	logic booting; // startup copy running
	logic [3:0] code_val, pin_sel; // code register and its pin selects
	logic [3:0] ctl_code; // code this device answers to
	logic [7:0] ram_protect_byte, nvm_protect_byte; // protection bytes
	logic protect_lock_bit; // protection frozen
	logic space_ram, space_nvm; // block decode
	logic byte_done; // last bit of a received or sent byte just ended
	logic wr_go; // data byte complete, commit now
	logic rd_done; // sent byte complete
	logic ram_we, nvm_we; // memory writes
	logic [7:0] ram_waddr, ram_wdata, nvm_raddr; // memory port muxes
	logic [7:0] ram_rdata, nvm_rdata; // memory read data
	logic [7:0] scratch; // byte with no nvm backing
	logic [7:0] rd_byte; // byte to send next

	assign sda_drive = 1'b0; // open drain: only ever pulls low

	// ----------------------------------------
	// line edges and bus conditions
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_line;
			sda_q <= sda_line;
		end
	end

	assign scl_rise = scl_line && !scl_q;
	assign scl_fall = !scl_line && scl_q;
	assign start_seen = scl_line && scl_q && sda_q && !sda_line;
	assign stop_seen = scl_line && scl_q && !sda_q && sda_line;

	// ----------------------------------------
	// control code and block decode
	// ----------------------------------------
	// each code bit from its pin or from the register
	assign ctl_code = (pin_sel & {code_pin_msb, code_pin_b2, code_pin_b1, code_pin_lsb})
		| (~pin_sel & code_val);

	// ram space ignores the low block bit, nvm needs all three
	assign space_ram = ptr[10:9] == BLK_RAM_TOP;
	assign space_nvm = ptr[10:8] == BLK_NVM;

	assign byte_done = scl_fall && cnt == BIT_LAST;
	assign wr_go = byte_done && state == ST_WDATA;
	assign rd_done = byte_done && state == ST_READ;

	// ----------------------------------------
	// startup copy from nvm to ram
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			booting <= 1'b1;
			boot_cnt <= 8'h00;
		end else if (booting) begin
			boot_cnt <= boot_cnt + 8'h01;
			if (boot_cnt == BOOT_LAST) begin
				booting <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// serial state machine
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			after_ack <= ST_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			sda_oe <= 1'b0;
		end else if (booting) begin
			state <= ST_IDLE; // bus ignored until the copy is done
			sda_oe <= 1'b0;
		end else if (start_seen) begin
			// also a repeated start: the pointer is left alone
			state <= ST_CTRL;
			cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_seen) begin
			state <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_CTRL, ST_WADDR, ST_WDATA: begin
					if (scl_rise && cnt != BIT_LAST) begin
						shreg <= {shreg[6:0], sda_line};
						cnt <= cnt + 4'h1;
					end else if (byte_done) begin
						cnt <= 4'h0;
						sda_oe <= 1'b1; // ack, dropped again on mismatch below
						state <= ST_ACK;
						if (state == ST_CTRL) begin
							if (shreg[7:4] == ctl_code) begin
								after_ack <= shreg[0] ? ST_READ : ST_WADDR;
							end else begin
								sda_oe <= 1'b0;
								state <= ST_IDLE;
							end
						end else begin
							after_ack <= ST_WDATA;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (after_ack == ST_READ) begin
							// first bit out on the same edge that ends the ack
							tx <= rd_byte;
							sda_oe <= !rd_byte[7];
							cnt <= 4'h1;
						end else begin
							sda_oe <= 1'b0;
							cnt <= 4'h0;
						end
						state <= after_ack;
					end
				end
				ST_READ: begin
					if (byte_done) begin
						sda_oe <= 1'b0; // hand the line to the master
						cnt <= 4'h0;
						state <= ST_MACK;
					end else if (scl_fall) begin
						sda_oe <= !tx[6];
						tx <= {tx[6:0], 1'b0};
						cnt <= cnt + 4'h1;
					end
				end
				ST_MACK: begin
					// master ack asks for another byte, nack ends the read
					if (scl_rise) begin
						state <= sda_line ? ST_IDLE : ST_ACK;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// address pointer
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ptr <= 11'h000;
		end else if (!booting && byte_done) begin
			if (state == ST_CTRL && shreg[7:4] == ctl_code) begin
				ptr[10:8] <= shreg[3:1];
			end else if (state == ST_WADDR) begin
				ptr[7:0] <= shreg;
			end else if (wr_go || rd_done) begin
				ptr[7:0] <= ptr[7:0] + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// memory writes
	// ----------------------------------------
	// commit happens on the edge that raises the ack
	assign ram_we = booting || (wr_go && space_ram && ptr[7:0] != SCRATCH_WORD
		&& !prot_blocks(ram_protect_byte, ptr[7:0], 1'b1));
	assign nvm_we = wr_go && space_nvm
		&& !prot_blocks(nvm_protect_byte, ptr[7:0], 1'b1);
	assign ram_waddr = booting ? boot_cnt : ptr[7:0];
	assign ram_wdata = booting ? nvm_rdata : shreg;
	assign nvm_raddr = booting ? boot_cnt : ptr[7:0];

	// byte that lives only in ram-side flops
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scratch <= 8'h00;
		end else if (wr_go && space_ram && ptr[7:0] == SCRATCH_WORD
				&& !prot_blocks(ram_protect_byte, ptr[7:0], 1'b1)) begin
			scratch <= shreg;
		end
	end

	// ----------------------------------------
	// read data selection
	// ----------------------------------------
	always_comb begin
		rd_byte = RD_BLOCKED; // unused block or inhibited read
		if (space_ram && !prot_blocks(ram_protect_byte, ptr[7:0], 1'b0)) begin
			if (ptr[7:2] == MACRO_BASE[7:2]) begin
				rd_byte = macro_out[{ptr[1:0], 3'b000} +: 8];
			end else if (ptr[7:0] == SCRATCH_WORD) begin
				rd_byte = scratch;
			end else begin
				rd_byte = ram_rdata;
			end
		end else if (space_nvm && !prot_blocks(nvm_protect_byte, ptr[7:0], 1'b0)) begin
			rd_byte = nvm_rdata;
		end
	end

	// ----------------------------------------
	// memories and register bus
	// ----------------------------------------
	// volatile configuration, also read by the macrocells
	icm_mem #(.DEPTH(DEPTH), .AW(8)) u_ram (
		.clock(clock),
		.rstn(rstn),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.raddr_a(ptr[7:0]),
		.rdata_a(ram_rdata),
		.raddr_b(cfg_raddr),
		.rdata_b(cfg_rdata)
	);

	// non-volatile configuration store
	icm_mem #(.DEPTH(DEPTH), .AW(8)) u_nvm (
		.clock(clock),
		.rstn(rstn),
		.we(nvm_we),
		.waddr(ptr[7:0]),
		.wdata(shreg),
		.raddr_a(nvm_raddr),
		.rdata_a(nvm_rdata),
		.raddr_b(8'h00),
		.rdata_b()
	);

	// software side: code setup, protection, status
	icm_axil u_axil (
		.clock(clock),
		.rstn(rstn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.code_val(code_val),
		.pin_sel(pin_sel),
		.ram_protect_byte(ram_protect_byte),
		.nvm_protect_byte(nvm_protect_byte),
		.protect_lock_bit(protect_lock_bit),
		.ptr_now(ptr),
		.booting(booting),
		.macro_out(macro_out)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	a_ack_on_match: assert property (
		(!booting && !start_seen && !stop_seen && byte_done && state == ST_CTRL
			&& shreg[7:4] == ctl_code) |=> sda_oe && state == ST_ACK)
		else $error("matching control byte not acknowledged");

	a_no_ack_miss: assert property (
		(!booting && !start_seen && !stop_seen && byte_done && state == ST_CTRL
			&& shreg[7:4] != ctl_code) |=> !sda_oe && state == ST_IDLE)
		else $error("mismatched control byte acknowledged");

	a_boot_copy_len: assert property (
		$fell(booting) |-> $past(boot_cnt) == BOOT_LAST && boot_cnt == 8'h00)
		else $error("startup copy wrong length");

	a_commit_with_ack: assert property (
		(ram_we && !booting && !start_seen && !stop_seen) |=> sda_oe ##1 sda_oe[*1])
		else $error("write not tied to data acknowledge");

	a_word_load: assert property (
		(!booting && !start_seen && !stop_seen && byte_done && state == ST_WADDR)
			|=> ptr[7:0] == $past(shreg) && $stable(ptr[10:8]))
		else $error("word address not loaded");

	a_ptr_advance: assert property (
		(!booting && wr_go && !start_seen && !stop_seen)
			|=> ptr[7:0] == $past(ptr[7:0]) + 8'h01)
		else $error("pointer did not advance after data byte");

	a_protect_write: assert property (
		ram_protect_byte[PROT_WR_INH] && !ram_protect_byte[PROT_UPPER] |-> booting || !ram_we)
		else $error("write reached protected ram");

	a_nvm_space_only: assert property (
		nvm_we |-> ptr[10:8] == BLK_NVM && state == ST_WDATA)
		else $error("nvm written outside its block");
endmodule // icm_i2c_slave
`default_nettype wire

// *** icm_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial bus master model, open drain on both lines
// ----------------------------------------
module icm_i2c_master #(
	parameter int H = 10
) (
	input wire logic clock,
	input wire logic sda_line,
	output logic scl_pull,
	output logic sda_pull
);
	// both lines released at start
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// wait n system clocks, changes land after the edge
	task automatic w(input int n);
		repeat (n) @(posedge clock);
	endtask
	// start or repeated start, data falls while clock high
	task automatic start();
		sda_pull <= 1'b0;
		w(H);
		scl_pull <= 1'b0;
		w(H);
		sda_pull <= 1'b1;
		w(H);
		scl_pull <= 1'b1;
		w(H);
	endtask
	// one bit: data set while clock low, sampled mid high
	task automatic bit_io(input logic b, output logic r);
		sda_pull <= !b;
		w(H);
		scl_pull <= 1'b0;
		w(H);
		r = sda_line;
		w(H);
		scl_pull <= 1'b1;
		w(H);
	endtask
	// stop, data rises while clock high
	task automatic stop();
		sda_pull <= 1'b1;
		w(H);
		scl_pull <= 1'b0;
		w(H);
		sda_pull <= 1'b0;
		w(H);
	endtask
	// byte out msb first, then listen for the acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	// byte in, then acknowledge if more wanted
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(!more, r);
	endtask
endmodule // icm_i2c_master
`default_nettype wire

// *** icm_i2c_slave_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module icm_i2c_slave_tb import icm_pkg::*;;
	logic clock, rstn, scl_pull, sda_pull, sda_oe, sda_drive, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready, res_stb;
	logic [3:0] pins, wstrb, code, p;
	logic [7:0] awaddr, araddr, cfg_raddr, cfg_rdata, a, d0, d1, d2, d3;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] wdata, rdata, macro_out, res_val, r;
	logic [31:0] exp_q[$];
	string name_q[$];
	int n_mismatch, comparisons, cycles;
	// pull-ups on both lines
	wire logic scl_line = !scl_pull;
	wire logic sda_line = !(sda_pull || (sda_oe && !sda_drive));
	icm_i2c_master u_mst (.clock(clock), .sda_line(sda_line), .scl_pull(scl_pull),
		.sda_pull(sda_pull));
	icm_i2c_slave u_dut (.clock(clock), .rstn(rstn), .scl_line(scl_line), .sda_line(sda_line),
		.sda_drive(sda_drive), .sda_oe(sda_oe), .code_pin_lsb(pins[0]), .code_pin_b1(pins[1]),
		.code_pin_b2(pins[2]), .code_pin_msb(pins[3]), .macro_out(macro_out),
		.cfg_raddr(cfg_raddr), .cfg_rdata(cfg_rdata), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// verdict and end of run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			n_mismatch++;
			conclude();
		end
	end
	// watcher: oldest note against each posted result
	always @(posedge clock) begin
		if (res_stb === 1'b1) begin
			comparisons++;
			if (res_val !== exp_q[0]) begin
				n_mismatch++;
				$display("[FAIL] %s expected %h seen %h", name_q[0], exp_q[0], res_val);
			end
			void'(exp_q.pop_front());
			void'(name_q.pop_front());
		end
	end
	// note expectation, post result
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		exp_q.push_back(e);
		name_q.push_back(n);
		res_val <= g;
		res_stb <= 1'b1;
		@(posedge clock);
		res_stb <= 1'b0;
		@(posedge clock);
	endtask
	// axi4-lite write, handshakes judged from settled values
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
			output logic [1:0] resp);
		logic aw, wd, b;
		b = 1'b0;
		@(posedge clock);
		awaddr <= ad;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge clock);
			aw = awvalid && awready;
			wd = wvalid && wready;
			b = bvalid;
			resp = bresp;
			@(posedge clock);
			if (aw) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
			if (b) bready <= 1'b0;
		end
	endtask
	// axi4-lite read
	task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] resp);
		logic ar, v;
		v = 1'b0;
		@(posedge clock);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!v) begin
			@(negedge clock);
			ar = arvalid && arready;
			v = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge clock);
			if (ar) arvalid <= 1'b0;
			if (v) rready <= 1'b0;
		end
	endtask
	// serial byte out with acknowledge check
	task automatic tx(input logic [7:0] b, input logic e);
		logic ak;
		u_mst.wr_byte(b, ak);
		check("ack", 32'(e), 32'(ak));
	endtask
	// serial byte in with data check
	task automatic rx(input logic more, input logic [7:0] e);
		logic [7:0] d;
		u_mst.rd_byte(more, d);
		check("rdata", 32'(e), 32'(d));
	endtask
	// write command: control, word address, data bytes
	task automatic wr_seq(input logic [2:0] b, input logic [7:0] ad, input logic [7:0] d[$]);
		u_mst.start();
		tx({code, b, 1'b0}, 1'b1);
		tx(ad, 1'b1);
		foreach (d[i]) tx(d[i], 1'b1);
		u_mst.stop();
	endtask
	// random read: address set, repeated start, read bytes
	task automatic rd_seq(input logic [2:0] b, input logic [7:0] ad, input logic [7:0] e[$]);
		u_mst.start();
		tx({code, b, 1'b0}, 1'b1);
		tx(ad, 1'b1);
		u_mst.start();
		tx({code, b, 1'b1}, 1'b1);
		foreach (e[i]) rx(i < e.size() - 1, e[i]);
		u_mst.stop();
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, res_stb} = '0;
		{awaddr, araddr, wstrb, wdata, res_val, macro_out, pins, cfg_raddr} = '0;
		code = CODE_DEFAULT;
		void'($urandom(93965));
		a = 8'($urandom_range(200));
		{d0, d1, d2, d3} = $urandom;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		r = 32'hffffffff;
		while (r[STAT_BOOT_BIT] !== 1'b0) axi_rd(REG_STATUS, r, rs);
		axi_rd(REG_CODE, r, rs);
		check("code", 32'h1, r);
		// byte write, committed at its acknowledge before stop
		cfg_raddr <= a;
		u_mst.start();
		tx({code, 3'h0, 1'b0}, 1'b1);
		tx(a, 1'b1);
		tx(d0, 1'b1);
		check("cfg", 32'(d0), 32'(cfg_rdata));
		u_mst.stop();
		rd_seq(3'h0, a, {d0});
		wr_seq(BLK_NVM, a, {d1, d2, d3});
		rd_seq(BLK_NVM, a, {d1, d2, d3});
		wr_seq(3'h1, a, {d3});
		rd_seq(3'h0, a, {d3});
		for (int b = 3; b < 8; b++) begin
			wr_seq(3'(b), a, {8'h5a});
			rd_seq(3'(b), a, {RD_BLOCKED});
		end
		rd_seq(3'h0, a, {d3});
		u_mst.start();
		tx({4'h2, 3'h0, 1'b1}, 1'b0);
		u_mst.stop();
		// control code from pins
		p = CODE_DEFAULT ^ 4'($urandom_range(1, 15));
		pins <= p;
		axi_wr(REG_CODE, 32'hf1, 4'h1, rs);
		check("bresp", 32'(RESP_OKAY), 32'(rs));
		code = p;
		wr_seq(3'h0, a, {d2});
		rd_seq(3'h0, a, {d2});
		u_mst.start();
		tx({CODE_DEFAULT, 3'h0, 1'b1}, 1'b0);
		u_mst.stop();
		axi_wr(REG_CODE, 32'h1, 4'h1, rs);
		code = CODE_DEFAULT;
		// protection: write inhibit, read inhibit, lock
		axi_wr(REG_PROT, 32'h2, 4'h1, rs);
		wr_seq(3'h0, a, {~d2});
		axi_wr(REG_PROT, 32'h1, 4'h1, rs);
		rd_seq(3'h0, a, {RD_BLOCKED});
		// nvm read inhibit on the upper half only
		axi_wr(REG_PROT, 32'h0500, 4'h2, rs);
		rd_seq(BLK_NVM, a, {a[7] ? RD_BLOCKED : d1});
		axi_wr(REG_PROT, 32'h10000, 4'h7, rs);
		rd_seq(3'h0, a, {d2});
		axi_wr(REG_PROT, 32'h0303, 4'h3, rs);
		axi_rd(REG_PROT, r, rs);
		check("prot", 32'h10000, r);
		// macrocell levels, scratch byte, unmapped place
		macro_out <= $urandom;
		wr_seq(3'h0, SCRATCH_WORD, {d1});
		rd_seq(3'h0, SCRATCH_WORD, {d1});
		axi_rd(REG_MACRO, r, rs);
		check("macro", macro_out, r);
		rd_seq(3'h0, MACRO_BASE, {macro_out[7:0], macro_out[15:8],
			macro_out[23:16], macro_out[31:24]});
		axi_rd(8'h10, r, rs);
		check("rresp", 32'(RESP_SLVERR), 32'(rs));
		axi_wr(8'h10, 32'h0, 4'hf, rs);
		check("bresp", 32'(RESP_SLVERR), 32'(rs));
		// second reset: ram must reload the nvm bytes written above
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		r = 32'hffffffff;
		while (r[STAT_BOOT_BIT] !== 1'b0) axi_rd(REG_STATUS, r, rs);
		rd_seq(3'h0, a, {d1, d2, d3});
		conclude();
	end
endmodule // icm_i2c_slave_tb
`default_nettype wire
